// *** core/rcp_radio_port.sv ***
// radio control port: general purpose pins with radio front end alternates
// assumes classic wishbone on clk_i and a free running link clock for the shifter
`timescale 1ns/1ps

// Functional notes
// - unselected pins act as plain bidirectional port bits
// - two mode bits encode RF/IF operating state
// - separate IF and RF latch strobes, shared data
// - each transfer shifts exactly one 20-bit word
// - synthesizer clock and data are firmware toggled while no transfer runs
// - power enable feeds RF/IF parts only
// - transmit enable is active high
// - calibration output starts receive offset calibration
// - two antenna switch outputs are driven
module rcp_radio_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [10:0] pin_in_i,
  output logic [10:0] pin_out_o,
  output logic [10:0] pin_oe_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_sel

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [10:0] out_ff;
  logic [10:0] dir_ff;
  logic [10:0] alt_ff;
  rcp_pkg::rcp_ctrl_s ctrl_ff;
  logic [19:0] word_ff;
  logic tgt_ff;
  logic req_tgl_ff;
  logic done_s1_ff;
  logic done_s2_ff;
  logic [10:0] in_s1_ff;
  logic [10:0] in_s2_ff;
  logic [10:0] in_s3_ff;
  logic [10:0] in_ff;
  rcp_pkg::rcp_ser_s ser_s1_ff;
  rcp_pkg::rcp_ser_s ser_s2_ff;
  logic [10:0] pin_out_ff;
  logic [10:0] pin_oe_ff;
  logic req;
  logic wr;
  logic busy;
  logic [10:0] alt_eff;
  logic [10:0] alt_val;
  logic [31:0] nxt_dat;
  logic lrst_req_ff;
  logic lrst_ack_s1_ff;
  logic lrst_ack_s2_ff;
  logic lrst_busy;

  // link domain
  logic lrst_s1_ff;
  logic lrst_s2_ff;
  logic lreq_s1_ff;
  logic lreq_s2_ff;
  logic lreq_s3_ff;
  logic done_tgl_ff;
  rcp_pkg::rcp_shift_e state_ff;
  logic [19:0] shreg_ff;
  logic [4:0] bitcnt_ff;
  logic phase_ff;
  logic ltgt_ff;
  rcp_pkg::rcp_ser_s ser_ff;
  logic lstart;

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = req & wb_we_i;
  assign busy = (req_tgl_ff ^ done_s2_ff) | lrst_busy;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= req;
    end
  end

  always_comb
  begin
    nxt_dat = 32'h0000_0000;
    if (wb_adr_i == rcp_pkg::ADR_OUT)
    begin
      nxt_dat[10:0] = out_ff;
    end
    else if (wb_adr_i == rcp_pkg::ADR_DIR)
    begin
      nxt_dat[10:0] = dir_ff;
    end
    else if (wb_adr_i == rcp_pkg::ADR_ALT)
    begin
      nxt_dat[10:0] = alt_ff;
    end
    else if (wb_adr_i == rcp_pkg::ADR_IN)
    begin
      nxt_dat[10:0] = in_ff;
    end
    else if (wb_adr_i == rcp_pkg::ADR_CTRL)
    begin
      nxt_dat[7:0] = ctrl_ff;
    end
    else if (wb_adr_i == rcp_pkg::ADR_SER)
    begin
      nxt_dat[19:0] = word_ff;
      nxt_dat[rcp_pkg::SER_TGT_BIT] = tgt_ff;
    end
    else if (wb_adr_i == rcp_pkg::ADR_STAT)
    begin
      nxt_dat[rcp_pkg::STAT_BUSY_BIT] = busy;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_ff <= 32'h0000_0000;
    end
    else if (req)
    begin
      dat_ff <= nxt_dat;
    end
  end

  // ----------------------------------------
  // port registers
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_ff <= rcp_pkg::RST_OUT;
      dir_ff <= rcp_pkg::RST_DIR;
      alt_ff <= rcp_pkg::RST_ALT;
    end
    else if (wr && wb_adr_i == rcp_pkg::ADR_OUT)
    begin
      out_ff <= 11'(merge_sel({21'h000000, out_ff}, wb_dat_i, wb_sel_i));
    end
    else if (wr && wb_adr_i == rcp_pkg::ADR_DIR)
    begin
      dir_ff <= 11'(merge_sel({21'h000000, dir_ff}, wb_dat_i, wb_sel_i));
    end
    else if (wr && wb_adr_i == rcp_pkg::ADR_ALT)
    begin
      alt_ff <= 11'(merge_sel({21'h000000, alt_ff}, wb_dat_i, wb_sel_i));
    end
  end

  // mode, power, transmit, calibration, antenna and synthesizer bit-bang bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_ff <= rcp_pkg::RST_CTRL;
    end
    else if (wr && wb_adr_i == rcp_pkg::ADR_CTRL && wb_sel_i[0])
    begin
      ctrl_ff <= wb_dat_i[7:0];
    end
  end

  // serial word: a write starts one transfer; ignored while a transfer runs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      word_ff <= 20'h00000;
      tgt_ff <= 1'b0;
      req_tgl_ff <= 1'b0;
    end
    else if (wr && wb_adr_i == rcp_pkg::ADR_SER && !busy)
    begin
      word_ff <= wb_dat_i[19:0];
      tgt_ff <= wb_dat_i[rcp_pkg::SER_TGT_BIT];
      req_tgl_ff <= ~req_tgl_ff;
    end
  end

  // ----------------------------------------
  // crossings into the bus domain
  // ----------------------------------------
  // the link clock may not tick during a short bus reset, so the link side is
  // reset by a request that stays up until the link side echoes it back
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lrst_req_ff <= 1'b1;
      lrst_ack_s1_ff <= 1'b0;
      lrst_ack_s2_ff <= 1'b0;
    end
    else
    begin
      lrst_ack_s1_ff <= lrst_s2_ff;
      lrst_ack_s2_ff <= lrst_ack_s1_ff;
      if (lrst_ack_s2_ff)
      begin
        lrst_req_ff <= 1'b0;
      end
    end
  end

  // link side counts as busy until the echo has fallen again
  assign lrst_busy = lrst_req_ff | lrst_ack_s2_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || lrst_busy)
    begin
      done_s1_ff <= 1'b0;
      done_s2_ff <= 1'b0;
      ser_s1_ff <= '0;
      ser_s2_ff <= '0;
    end
    else
    begin
      done_s1_ff <= done_tgl_ff;
      done_s2_ff <= done_s1_ff;
      ser_s1_ff <= ser_ff;
      ser_s2_ff <= ser_s1_ff;
    end
  end

  // pin inputs: a change counts once the second and third stages agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in_s1_ff <= 11'h000;
      in_s2_ff <= 11'h000;
      in_s3_ff <= 11'h000;
    end
    else
    begin
      in_s1_ff <= pin_in_i;
      in_s2_ff <= in_s1_ff;
      in_s3_ff <= in_s2_ff;
    end
  end

  // ----------------------------------------
  // pin multiplexing
  // ----------------------------------------
  // the antenna pair shares one select so the two can never split
  always_comb
  begin
    alt_eff = alt_ff;
    alt_eff[rcp_pkg::PIN_ANT_INV] = alt_ff[rcp_pkg::PIN_ANT_TRUE];
  end

  always_comb
  begin
    alt_val = 11'h000;
    alt_val[rcp_pkg::PIN_MODE_A] = ctrl_ff.mode[0];
    alt_val[rcp_pkg::PIN_MODE_B] = ctrl_ff.mode[1];
    alt_val[rcp_pkg::PIN_IF_LE] = ser_s2_ff.if_chip_latch_strobe;
    alt_val[rcp_pkg::PIN_RF_LE] = ser_s2_ff.rf_chip_latch_strobe;
    alt_val[rcp_pkg::PIN_POWER] = ctrl_ff.power;
    alt_val[rcp_pkg::PIN_TX_EN] = ctrl_ff.tx;
    alt_val[rcp_pkg::PIN_CAL] = ctrl_ff.cal;
    alt_val[rcp_pkg::PIN_ANT_TRUE] = ctrl_ff.ant;
    alt_val[rcp_pkg::PIN_ANT_INV] = ~ctrl_ff.ant;
    // the shifter borrows the shared clock and data pins only while it runs
    alt_val[rcp_pkg::PIN_SYN_CLK] = ser_s2_ff.act ? ser_s2_ff.sclk : ctrl_ff.sclk;
    alt_val[rcp_pkg::PIN_SYN_DAT] = ser_s2_ff.act ? ser_s2_ff.sdata : ctrl_ff.sdat;
  end

  for (genvar g = 0; g < rcp_pkg::PIN_CNT; g++)
  begin : g_pin
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        pin_out_ff[g] <= 1'b0;
        pin_oe_ff[g] <= 1'b0;
        in_ff[g] <= 1'b0;
      end
      else
      begin
        pin_out_ff[g] <= alt_eff[g] ? alt_val[g] : out_ff[g];
        pin_oe_ff[g] <= alt_eff[g] | dir_ff[g];
        if (in_s2_ff[g] == in_s3_ff[g])
        begin
          in_ff[g] <= in_s3_ff[g];
        end
      end
    end
  end

  // ----------------------------------------
  // link domain: serial shifter
  // ----------------------------------------
  always_ff @(posedge link_clk_i)
  begin
    lrst_s1_ff <= lrst_req_ff;
    lrst_s2_ff <= lrst_s1_ff;
  end

  always_ff @(posedge link_clk_i)
  begin
    if (lrst_s2_ff)
    begin
      lreq_s1_ff <= 1'b0;
      lreq_s2_ff <= 1'b0;
      lreq_s3_ff <= 1'b0;
    end
    else
    begin
      lreq_s1_ff <= req_tgl_ff;
      lreq_s2_ff <= lreq_s1_ff;
      lreq_s3_ff <= lreq_s2_ff;
    end
  end

  // word_ff and tgt_ff hold still while busy, so reading them here is safe
  assign lstart = lreq_s2_ff ^ lreq_s3_ff;

  always_ff @(posedge link_clk_i)
  begin
    if (lrst_s2_ff)
    begin
      state_ff <= rcp_pkg::SH_IDLE;
      shreg_ff <= 20'h00000;
      bitcnt_ff <= 5'h00;
      phase_ff <= 1'b0;
      ltgt_ff <= 1'b0;
      ser_ff <= '0;
      done_tgl_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        rcp_pkg::SH_IDLE:
        begin
          if (lstart)
          begin
            shreg_ff <= word_ff;
            ltgt_ff <= tgt_ff;
            bitcnt_ff <= 5'h00;
            phase_ff <= 1'b0;
            ser_ff.act <= 1'b1;
            ser_ff.sclk <= 1'b0;
            ser_ff.if_chip_latch_strobe <= ~tgt_ff;
            ser_ff.rf_chip_latch_strobe <= tgt_ff;
            state_ff <= rcp_pkg::SH_SHIFT;
          end
        end
        rcp_pkg::SH_SHIFT:
        begin
          phase_ff <= ~phase_ff;
          if (!phase_ff)
          begin
            ser_ff.sclk <= 1'b0;
            ser_ff.sdata <= shreg_ff[19];
          end
          else
          begin
            ser_ff.sclk <= 1'b1;
            shreg_ff <= {shreg_ff[18:0], 1'b0};
            bitcnt_ff <= bitcnt_ff + 5'h01;
            if (bitcnt_ff == rcp_pkg::LAST_BIT)
            begin
              state_ff <= rcp_pkg::SH_LATCH;
            end
          end
        end
        rcp_pkg::SH_LATCH:
        begin
          ser_ff.sclk <= 1'b0;
          state_ff <= rcp_pkg::SH_DONE;
        end
        rcp_pkg::SH_DONE:
        begin
          // strobe falls after the last clock, which is when the chip latches
          ser_ff.if_chip_latch_strobe <= 1'b0;
          ser_ff.rf_chip_latch_strobe <= 1'b0;
          ser_ff.act <= 1'b0;
          done_tgl_ff <= ~done_tgl_ff;
          state_ff <= rcp_pkg::SH_IDLE;
        end
        default:
        begin
          state_ff <= rcp_pkg::SH_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign pin_out_o = pin_out_ff;
  assign pin_oe_o = pin_oe_ff;

endmodule : rcp_radio_port

// *** inc/rcp_pkg.sv ***
// constants and types for the radio control port
// assumes a 32-bit classic wishbone master and one link clock for the serial shifter
package rcp_pkg;

  // ----------------------------------------
  // pin map
  // ----------------------------------------
  localparam int unsigned PIN_CNT = 11;
  localparam int unsigned PIN_MODE_A = 0;
  localparam int unsigned PIN_IF_LE = 1;
  localparam int unsigned PIN_POWER = 2;
  localparam int unsigned PIN_RF_LE = 3;
  localparam int unsigned PIN_SYN_CLK = 4;
  localparam int unsigned PIN_SYN_DAT = 5;
  localparam int unsigned PIN_TX_EN = 6;
  localparam int unsigned PIN_MODE_B = 7;
  localparam int unsigned PIN_CAL = 8;
  localparam int unsigned PIN_ANT_INV = 9;
  localparam int unsigned PIN_ANT_TRUE = 10;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADR_OUT = 8'h00;
  localparam logic [7:0] ADR_DIR = 8'h04;
  localparam logic [7:0] ADR_ALT = 8'h08;
  localparam logic [7:0] ADR_IN = 8'h0C;
  localparam logic [7:0] ADR_CTRL = 8'h10;
  localparam logic [7:0] ADR_SER = 8'h14;
  localparam logic [7:0] ADR_STAT = 8'h18;

  // ----------------------------------------
  // reset values and field positions
  // ----------------------------------------
  localparam logic [10:0] RST_OUT = 11'h000;
  localparam logic [10:0] RST_DIR = 11'h000;
  localparam logic [10:0] RST_ALT = 11'h000;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam int unsigned WORD_BITS = 20;
  localparam logic [4:0] LAST_BIT = 5'h13;
  localparam int unsigned SER_TGT_BIT = 24;
  localparam int unsigned STAT_BUSY_BIT = 0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  // firmware control register, bit 0 is mode[0]
  typedef struct packed {
    logic sdat;
    logic sclk;
    logic ant;
    logic cal;
    logic tx;
    logic power;
    logic [1:0] mode;
  } rcp_ctrl_s;

  // serial shifter pin group, made in the link domain
  typedef struct packed {
    logic act;
    logic rf_chip_latch_strobe;
    logic if_chip_latch_strobe;
    logic sdata;
    logic sclk;
  } rcp_ser_s;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_SHIFT = 2'b01,
    SH_LATCH = 2'b11,
    SH_DONE = 2'b10
  } rcp_shift_e;

endpackage : rcp_pkg

// *** tb/rcp_radio_model.sv ***
// behavioural IF and RF chip serial input registers
// assumes strobe, clock and data arrive on the port pins as driven
`timescale 1ns/1ps
module rcp_radio_model (
  input wire logic [10:0] pin_out_i,
  input wire logic [10:0] pin_oe_i,
  output logic [19:0] if_word_o,
  output logic [19:0] rf_word_o
);
  logic [19:0] shift_ff;
  // only the newest 20 bits survive, older ones fall off the top
  always @(posedge pin_out_i[4])
    if (pin_oe_i[4])
      shift_ff <= {shift_ff[18:0], pin_out_i[5]};
  always @(negedge pin_out_i[1])
    if_word_o <= shift_ff;
  always @(negedge pin_out_i[3])
    rf_word_o <= shift_ff;
endmodule : rcp_radio_model

// *** tb/rcp_radio_port_properties.sv ***
// checker for the radio control port bus handshake and radio pins
// assumes it is bound to rcp_radio_port and sees only its ports
`timescale 1ns/1ps
module rcp_radio_port_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic [10:0] pin_out_o,
  input wire logic [10:0] pin_oe_o
);
  logic strb;
  logic [5:0] bits_ff;
  assign strb = pin_out_o[1] | pin_out_o[3];
  // clock rises seen inside one strobe; pins are slow enough to sample on clk_i
  always_ff @(posedge clk_i)
    if (rst_i || !strb)
      bits_ff <= 6'h00;
    else if ($rose(pin_out_o[4]))
      bits_ff <= bits_ff + 6'h01;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  oe_cause_a: assert property ($changed(pin_oe_o) |-> $past(wb_ack_o && wb_we_i))
    else $error("enable changed without write");
  strobe_excl_a: assert property (!(pin_out_o[1] && pin_out_o[3]))
    else $error("both strobes high");
  word_len_a: assert property ($fell(strb) |-> bits_ff == 6'h14)
    else $error("word length wrong");
  data_set_a: assert property ($rose(pin_out_o[4]) |-> $stable(pin_out_o[5]))
    else $error("data moved at clock");
  strobe_frame_a: assert property ($changed(strb) |-> !pin_out_o[4])
    else $error("strobe moved with clock high");
  ant_compl_a: assert property (pin_oe_o[10] |-> pin_oe_o[9] && pin_out_o[9] != pin_out_o[10])
    else $error("antenna pair not complementary");
  cover property ($fell(pin_out_o[1]));
  cover property ($fell(pin_out_o[3]));
  cover property (pin_oe_o[10] && pin_out_o[10]);
endmodule : rcp_radio_port_properties

bind rcp_radio_port rcp_radio_port_properties rcp_radio_port_properties_inst (.clk_i,
  .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .pin_out_o, .pin_oe_o);

// *** tb/tb_rcp_radio_port.sv ***
// self-checking bench for the radio control port
// assumes the design, the chip model and the bound checker are compiled first
`timescale 1ns/1ps
module tb_rcp_radio_port;
  logic clk_i = 1'b0;
  logic link_clk = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic [10:0] ext = 11'h200;
  logic [10:0] pout;
  logic [10:0] poe;
  logic [19:0] if_word;
  logic [19:0] rf_word;
  logic [7:0] c;
  int i;
  int n_fail = 0;
  int n_checks = 0;
  always #5 clk_i = ~clk_i;
  initial #7 forever #24 link_clk = ~link_clk;
  // undriven pins settle to the board pulls held in ext
  rcp_radio_port rcp_radio_port_inst (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_in_i((poe & pout) | (~poe & ext)),
    .pin_out_o(pout), .pin_oe_o(poe));
  rcp_radio_model rcp_radio_model_inst (.pin_out_i(pout), .pin_oe_i(poe),
    .if_word_o(if_word), .rf_word_o(rf_word));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wait_idle;
    do bus(1'b0, rcp_pkg::ADR_STAT, 32'h0); while (q[0] !== 1'b0);
  endtask : wait_idle
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  initial
  begin
    #300000;
    n_fail++;
    $display("[FAIL] %0t watchdog", $time);
    end_sim;
  end
  initial
  begin
    // short reset; the design holds STAT busy until its link side is reset
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(poe, 32'h0);
    wait_idle;
    for (i = 0; i < 8; i++)
    begin
      bus(1'b0, 8'(i * 4), 32'h0);
      chk(q, (i == 3) ? {21'h0, ext} : 32'h0);
    end
    bus(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, rcp_pkg::ADR_OUT, 32'h5A5);
    bus(1'b1, rcp_pkg::ADR_DIR, 32'h7FF);
    @(posedge clk_i);
    chk(pout, 32'h5A5);
    chk(poe, 32'h7FF);
    bus(1'b1, rcp_pkg::ADR_DIR, 32'h0);
    ext <= 11'h3C3;
    repeat (8) @(posedge clk_i);
    bus(1'b0, rcp_pkg::ADR_IN, 32'h0);
    chk(q, 32'h3C3);
    bus(1'b1, rcp_pkg::ADR_ALT, 32'h7FF);
    for (i = 0; i < 9; i++)
    begin
      c = 8'(9'h001 << i);
      bus(1'b1, rcp_pkg::ADR_CTRL, {24'h0, c});
      @(posedge clk_i);
      chk(pout, {c[5], ~c[5], c[4], c[1], c[3], c[7], c[6], 1'b0, c[2], 1'b0, c[0]});
    end
    bus(1'b1, rcp_pkg::ADR_SER, 32'h000A5C3E);
    wait_idle;
    chk(if_word, 32'hA5C3E);
    bus(1'b1, rcp_pkg::ADR_SER, 32'h0105A3C1);
    bus(1'b1, rcp_pkg::ADR_SER, 32'h010FFFFF);
    bus(1'b0, rcp_pkg::ADR_SER, 32'h0);
    chk(q, 32'h0105A3C1);
    bus(1'b0, rcp_pkg::ADR_STAT, 32'h0);
    chk(q, 32'h1);
    wait_idle;
    chk(rf_word, 32'h5A3C1);
    chk(if_word, 32'hA5C3E);
    // firmware sets data first, then raises the clock
    bus(1'b1, rcp_pkg::ADR_CTRL, 32'h80);
    @(posedge clk_i);
    chk(pout[5:4], 32'h2);
    bus(1'b1, rcp_pkg::ADR_CTRL, 32'hC0);
    @(posedge clk_i);
    chk(pout[5:4], 32'h3);
    end_sim;
  end
endmodule : tb_rcp_radio_port
